// *** logic/smb_map.svh ***
// Register map, field positions and codes of the slave port mailbox
`ifndef SMB_MAP_SVH
`define SMB_MAP_SVH
`define SMB_OFS_DATA0    8'h20
`define SMB_OFS_DATA1    8'h21
`define SMB_OFS_DATA2    8'h22
`define SMB_OFS_STATUS   8'h23
`define SMB_OFS_CONTROL  8'h24
`define SMB_EXT_STATUS   2'h3
`define SMB_CTL_IGNORE   7
`define SMB_CTL_PIN_HI   6
`define SMB_CTL_PIN_LO   5
`define SMB_ST_IN_IRQ    7
`define SMB_ST_IN_FULL0  4
`define SMB_ST_OUT_ATTN  3
`define SMB_MODE_IN      2'h0
`define SMB_MODE_OUT     2'h1
`define SMB_MODE_SLAVE   2'h2
`define SMB_MODE_AUX     2'h3
`define SMB_PRIO_OFF     2'h0
`define SMB_BOOT_COLD    2'h1
`define SMB_BOOT_RUN     2'h0
`define SMB_RST_MODE     2'h0
`define SMB_RST_PRIO     2'h0
`define SMB_FIFO_DEPTH   8
`define SMB_DATA_W       8
`endif

// *** logic/smb_pkg.sv ***
// Types shared by the slave port mailbox
package smb_pkg;
  typedef enum {SMB_RUN, SMB_BOOT} smb_state_t;
  typedef enum {SMB_CMD_HI, SMB_CMD_LO, SMB_CMD_DATA} smb_cmd_t;
endpackage

// *** logic/smb_flag.sv ***
// One handshake flag: hardware set wins over a clear
`timescale 1ns/10ps
module smb_flag
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic setFlag,
  input  wire logic clrFlag,
  output logic      flag
);
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      flag <= 1'b0;
    else if (clkEn && setFlag)
      flag <= 1'b1;
    else if (clkEn && clrFlag)
      flag <= 1'b0;
  end
endmodule

// *** logic/smb_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module smb_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push     = clkEn && inValid && inReady;
  assign pop      = clkEn && outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      if (pop)
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

// *** logic/smb_mailbox.sv ***
// Slave port mailbox: data, status and control registers, cold boot
`timescale 1ns/10ps
`include "smb_map.svh"
module smb_mailbox
  import smb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic [7:0]  ioAddr,
  input  wire logic        ioWrite,
  input  wire logic        ioRead,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  input  wire logic        portSelectN,
  input  wire logic        portReadStrobeN,
  input  wire logic        portWriteStrobeN,
  input  wire logic        portAddrBitLow,
  input  wire logic        portAddrBitHigh,
  input  wire logic [7:0]  portDataIn,
  output logic      [7:0]  portDataOut,
  output logic             portDataOe,
  output logic             attentionOutN,
  input  wire logic        bootModePinHigh,
  input  wire logic        bootModePinLow,
  output logic             slaveIrq,
  output logic      [1:0]  irqPriority,
  output logic             slavePortEn,
  output logic             portADirOut,
  output logic             auxBusEn,
  output logic             coreHalt,
  output logic             execStart,
  output logic      [14:0] bootAddr,
  output logic             bootIoSpace,
  output logic      [7:0]  bootData,
  output logic             bootStoreValid,
  input  wire logic        bootStoreReady
);
  logic [7:0] toMaster [3];
  logic [7:0] toSlave  [3];
  logic [7:0] fullFlags;
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic       bootIgnore;
  logic [1:0] portMode;
  logic       started;
  smb_state_t state;
  smb_cmd_t   cmdPhase;
  logic       mWrPrev;
  logic       mRdPrev;
  logic [1:0] mWrAddr;
  logic [1:0] mRdAddr;
  logic [7:0] mWrData;
  logic       fifoInReady;
  logic       fifoOutValid;
  logic [7:0] fifoOutData;
  logic       fifoPush;

  wire [1:0] portAddr = {portAddrBitHigh, portAddrBitLow};
  wire [1:0] bootPins = {bootModePinHigh, bootModePinLow};
  wire mWrAct = !portSelectN && !portWriteStrobeN;
  wire mRdAct = !portSelectN && !portReadStrobeN;
  // Either strobe rising ends the access, so one falling term catches both
  wire mWrDone = clkEn && mWrPrev && !mWrAct;
  wire mRdDone = clkEn && mRdPrev && !mRdAct;
  wire sWr = clkEn && ioWrite;
  wire sRd = clkEn && ioRead;
  wire sWrStatus = sWr && ioAddr == `SMB_OFS_STATUS;
  wire sWrCtrl = sWr && ioAddr == `SMB_OFS_CONTROL;
  wire mWrStatus = mWrDone && mWrAddr == `SMB_EXT_STATUS;
  wire fifoPop = clkEn && fifoOutValid && !bootStoreValid;

  // Master strobes are sampled; the last sample before release is kept
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mWrPrev <= 1'b0;
      mRdPrev <= 1'b0;
      mWrAddr <= 2'h0;
      mRdAddr <= 2'h0;
      mWrData <= 8'h00;
    end
    else if (clkEn)
    begin
      mWrPrev <= mWrAct;
      mRdPrev <= mRdAct;
      if (mWrAct)
      begin
        mWrAddr <= portAddr;
        mWrData <= portDataIn;
      end
      if (mRdAct)
        mRdAddr <= portAddr;
    end
  end

  // Separate stores per direction; each byte changes in one edge
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        toMaster[i] <= 8'h00;
        toSlave[i]  <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (sWr && ioAddr == `SMB_OFS_DATA0 + 8'(i))
          toMaster[i] <= ioWrData;
        if (mWrDone && mWrAddr == 2'(i))
          toSlave[i] <= mWrData;
      end
    end
  end

  always_comb
  begin
    setVec = 8'h00;
    clrVec = 8'h00;
    for (int i = 0; i < 3; i++)
    begin
      setVec[i] = sWr && ioAddr == `SMB_OFS_DATA0 + 8'(i);
      clrVec[i] = mRdDone && mRdAddr == 2'(i);
      setVec[`SMB_ST_IN_FULL0+i] = mWrDone && mWrAddr == 2'(i);
      clrVec[`SMB_ST_IN_FULL0+i] = sRd
                                   && ioAddr == `SMB_OFS_DATA0 + 8'(i);
    end
    // The boot engine consumes data 0 like a slave read would
    if (fifoPush)
      clrVec[`SMB_ST_IN_FULL0] = 1'b1;
    setVec[`SMB_ST_IN_IRQ] = setVec[`SMB_ST_IN_FULL0];
    clrVec[`SMB_ST_IN_IRQ] = sWrStatus;
    setVec[`SMB_ST_OUT_ATTN] = setVec[0];
    clrVec[`SMB_ST_OUT_ATTN] = mWrStatus;
  end

  // Status reads never enter clrVec, so peeking is harmless
  for (genvar g = 0; g < 8; g++)
  begin : gFlag
    smb_flag uFlag
    (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clkEn   (clkEn),
      .setFlag (setVec[g]),
      .clrFlag (clrVec[g]),
      .flag    (fullFlags[g])
    );
  end

  assign attentionOutN = !fullFlags[`SMB_ST_OUT_ATTN];
  assign slaveIrq = fullFlags[`SMB_ST_IN_IRQ]
                    && irqPriority != `SMB_PRIO_OFF;
  assign slavePortEn = (portMode == `SMB_MODE_SLAVE);
  assign portADirOut = (portMode == `SMB_MODE_OUT);
  assign auxBusEn = (portMode == `SMB_MODE_AUX);
  assign coreHalt = (state == SMB_BOOT);
  assign portDataOe = mRdAct;

  // Control register is on the slave side only
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      bootIgnore  <= 1'b0;
      portMode    <= `SMB_RST_MODE;
      irqPriority <= `SMB_RST_PRIO;
    end
    else if (clkEn && state == SMB_RUN && !started
             && !bootIgnore && bootPins == `SMB_BOOT_COLD)
      portMode <= `SMB_MODE_SLAVE;
    else if (sWrCtrl)
    begin
      bootIgnore  <= ioWrData[`SMB_CTL_IGNORE];
      portMode    <= ioWrData[3:2];
      irqPriority <= ioWrData[1:0];
    end
  end

  // Boot pins are checked for entry once, on the first enabled edge after reset, and for exit on every edge in boot
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      started   <= 1'b0;
      state     <= SMB_RUN;
      execStart <= 1'b0;
    end
    else if (clkEn)
    begin
      execStart <= 1'b0;
      started   <= 1'b1;
      unique case (state)
        SMB_RUN:
          if (!started && !bootIgnore && bootPins == `SMB_BOOT_COLD)
            state <= SMB_BOOT;
        SMB_BOOT:
          if (bootPins == `SMB_BOOT_RUN)
          begin
            state     <= SMB_RUN;
            execStart <= 1'b1;
          end
      endcase
    end
  end

  assign fifoPush = clkEn && coreHalt && fullFlags[`SMB_ST_IN_FULL0]
                    && fifoInReady;

  smb_fifo #(.WIDTH(`SMB_DATA_W), .DEPTH(`SMB_FIFO_DEPTH)) uCmdFifo
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .inValid  (coreHalt && fullFlags[`SMB_ST_IN_FULL0]),
    .inReady  (fifoInReady),
    .inData   (toSlave[0]),
    .outValid (fifoOutValid),
    .outReady (!bootStoreValid),
    .outData  (fifoOutData)
  );

  // Three-byte command: space and high address, low address, data
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cmdPhase       <= SMB_CMD_HI;
      bootAddr       <= 15'h0000;
      bootIoSpace    <= 1'b0;
      bootData       <= 8'h00;
      bootStoreValid <= 1'b0;
    end
    else if (clkEn)
    begin
      if (bootStoreValid && bootStoreReady)
        bootStoreValid <= 1'b0;
      if (fifoPop)
      begin
        unique case (cmdPhase)
          SMB_CMD_HI:
          begin
            bootIoSpace    <= fifoOutData[7];
            bootAddr[14:8] <= fifoOutData[6:0];
            cmdPhase       <= SMB_CMD_LO;
          end
          SMB_CMD_LO:
          begin
            bootAddr[7:0] <= fifoOutData;
            cmdPhase      <= SMB_CMD_DATA;
          end
          SMB_CMD_DATA:
          begin
            bootData       <= fifoOutData;
            bootStoreValid <= 1'b1;
            cmdPhase       <= SMB_CMD_HI;
          end
        endcase
      end
    end
  end

  // Read paths are registered so a sampled byte is never half updated
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ioRdData    <= 8'h00;
      portDataOut <= 8'h00;
    end
    else if (clkEn)
    begin
      unique case (portAddr)
        2'h0, 2'h1, 2'h2: portDataOut <= toMaster[portAddr];
        2'h3:             portDataOut <= fullFlags;
      endcase
      if (ioRead)
      begin
        unique case (ioAddr)
          `SMB_OFS_DATA0:  ioRdData <= toSlave[0];
          `SMB_OFS_DATA1:  ioRdData <= toSlave[1];
          `SMB_OFS_DATA2:  ioRdData <= toSlave[2];
          `SMB_OFS_STATUS: ioRdData <= fullFlags;
          `SMB_OFS_CONTROL:
            ioRdData <= {1'b0, bootModePinHigh, bootModePinLow,
                         5'h00};
          default:         ioRdData <= 8'h00;
        endcase
      end
    end
  end

  a_oe_window: assert property (@(posedge ref_clk) disable iff (!resetn)
    portDataOe |-> !portSelectN && !portReadStrobeN)
    else $error("data lines driven outside a read");
  a_attn_assert: assert property (@(posedge ref_clk) disable iff (!resetn)
    sWr && ioAddr == `SMB_OFS_DATA0 |=> !attentionOutN)
    else $error("attention not asserted");
  a_attn_release: assert property (@(posedge ref_clk) disable iff (!resetn)
    mWrStatus && !setVec[0] |=> attentionOutN)
    else $error("attention not released");
  a_inbound_irq: assert property (@(posedge ref_clk) disable iff (!resetn)
    mWrDone && mWrAddr == 2'h0 && irqPriority != 2'h0 && !sWrCtrl
    |=> slaveIrq)
    else $error("inbound interrupt missing");
  a_boot_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
    coreHalt && !sWrCtrl |=> slavePortEn)
    else $error("cold boot without slave port mode");
  a_boot_exit: assert property (@(posedge ref_clk) disable iff (!resetn)
    coreHalt && clkEn && bootPins == 2'h0 |=> execStart && !coreHalt)
    else $error("cold boot did not end");
  a_full_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    mWrDone && mWrAddr == 2'h1 |=> fullFlags[5])
    else $error("full flag not set by master write");
  a_store_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    bootStoreValid && !bootStoreReady |=> bootStoreValid
    && $stable(bootAddr) && $stable(bootData))
    else $error("boot store dropped");
  a_ctrl_private: assert property (@(posedge ref_clk) disable iff (!resetn)
    mWrDone && !sWrCtrl && !coreHalt && started |=> $stable(portMode))
    else $error("master reached control");
  a_prio_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    sWrCtrl && started |=> irqPriority == $past(ioWrData[1:0]))
    else $error("priority not written");
endmodule

// *** verif/smb_master_model.sv ***
// Master processor model driving the mailbox port pins
`timescale 1ns/10ps
module smb_master_model
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] portDataOut,
  input  wire logic       portDataOe,
  output logic            portSelectN,
  output logic            portReadStrobeN,
  output logic            portWriteStrobeN,
  output logic            portAddrBitLow,
  output logic            portAddrBitHigh,
  output wire logic [7:0] portDataIn
);
  logic       drive = 1'b0;
  logic [7:0] mData = 8'h00;

  // Released lines float high through the bus pull-ups
  assign portDataIn = portDataOe ? portDataOut : (drive ? mData : 8'hFF);

  initial
  begin
    {portSelectN, portReadStrobeN, portWriteStrobeN} = 3'h7;
    {portAddrBitHigh, portAddrBitLow} = 2'h0;
  end

  task automatic mwrite(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {portAddrBitHigh, portAddrBitLow} = a;
    {mData, drive} = {d, 1'b1};
    {portSelectN, portWriteStrobeN} = 2'h0;
    @(posedge ref_clk);
    #1;
    {portSelectN, portWriteStrobeN, drive} = 3'h6;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic mread(input logic [1:0] a, output logic [7:0] d,
                       output logic oe);
    @(posedge ref_clk);
    #1;
    {portAddrBitHigh, portAddrBitLow} = a;
    {portSelectN, portReadStrobeN} = 2'h0;
    repeat (3) @(posedge ref_clk);
    // Sample once the edge's updates have settled, before releasing
    #1;
    d = portDataIn;
    oe = portDataOe;
    {portSelectN, portReadStrobeN} = 2'h3;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Two equal reads so a transitional status value is never trusted
  task automatic mpoll(input int bitNo, output logic ok);
    logic [7:0] s0;
    logic [7:0] s1;
    logic       oe;
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++)
    begin
      mread(2'h3, s0, oe);
      mread(2'h3, s1, oe);
      ok = (s0 === s1) && !s0[bitNo];
    end
  endtask
endmodule

// *** verif/smb_mailbox_bench.sv ***
// Self-checking bench of the slave port mailbox against a register model
`timescale 1ns/10ps
`include "smb_map.svh"
module smb_mailbox_bench;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ioWrite = 1'b0;
  logic        ioRead = 1'b0;
  logic [7:0]  ioAddr = 8'h00;
  logic [7:0]  ioWrData = 8'h00;
  logic        pinHi = 1'b0;
  logic        pinLo = 1'b0;
  logic        storeReady = 1'b0;
  logic [31:0] seed = 32'h0626;
  logic [7:0]  tm [3];
  logic [7:0]  ts [3];
  logic [7:0]  st;
  logic [7:0]  bq [24];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  wire  [7:0]  ioRdData, portDataOut, portDataIn, bootData;
  wire         portDataOe, sel, rd, wr, a0, a1, attn, irq, spEn;
  wire         dirOut, aux, halt, exec, bootIo, storeValid;
  wire  [1:0]  prio;
  wire  [14:0] bootAddr;

  always #5 ref_clk = ~ref_clk;

  smb_master_model m
  (
    .ref_clk(ref_clk), .portDataOut(portDataOut), .portDataOe(portDataOe),
    .portSelectN(sel), .portReadStrobeN(rd), .portWriteStrobeN(wr),
    .portAddrBitLow(a0), .portAddrBitHigh(a1), .portDataIn(portDataIn)
  );

  smb_mailbox dut
  (
    .ref_clk(ref_clk), .resetn(resetn), .clkEn(1'b1), .ioAddr(ioAddr),
    .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .portSelectN(sel), .portReadStrobeN(rd),
    .portWriteStrobeN(wr), .portAddrBitLow(a0), .portAddrBitHigh(a1),
    .portDataIn(portDataIn), .portDataOut(portDataOut),
    .portDataOe(portDataOe), .attentionOutN(attn),
    .bootModePinHigh(pinHi), .bootModePinLow(pinLo), .slaveIrq(irq),
    .irqPriority(prio), .slavePortEn(spEn), .portADirOut(dirOut),
    .auxBusEn(aux), .coreHalt(halt), .execStart(exec),
    .bootAddr(bootAddr), .bootIoSpace(bootIo), .bootData(bootData),
    .bootStoreValid(storeValid), .bootStoreReady(storeReady)
  );

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {ioAddr, ioWrData, ioWrite} = {a, d, 1'b1};
    @(posedge ref_clk);
    #1;
    ioWrite = 1'b0;
  endtask

  task automatic srd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {ioAddr, ioRead} = {a, 1'b1};
    @(posedge ref_clk);
    #1;
    ioRead = 1'b0;
    d = ioRdData;
  endtask

  task automatic doReset(input logic [1:0] pins);
    {pinHi, pinLo, resetn, st} = {pins, 1'b0, 8'h00};
    repeat (4) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  initial
  begin
    logic [7:0] d;
    logic [7:0] e;
    logic       oe;
    logic       ok;
    doReset(2'h0);
    chk({attn, halt}, 2'h2);
    for (int i = 0; i < 3; i++)
    begin
      tm[i] = rnd();
      swr(8'(`SMB_OFS_DATA0 + i), tm[i]);
      st[i] = 1'b1;
    end
    st[3] = 1'b1;
    chk(attn, 1'b0);
    m.mread(`SMB_EXT_STATUS, d, oe);
    chk(d, st);
    for (int i = 0; i < 3; i++)
    begin
      m.mread(2'(i), d, oe);
      chk(d, tm[i]);
      chk(oe, 1'b1);
      st[i] = 1'b0;
    end
    srd(`SMB_OFS_STATUS, d);
    chk(d, st);
    m.mwrite(`SMB_EXT_STATUS, rnd());
    st[3] = 1'b0;
    chk({attn, portDataOe}, 2'h2);
    for (int i = 0; i < 3; i++)
    begin
      ts[i] = rnd();
      m.mwrite(2'(i), ts[i]);
      st[4 + i] = 1'b1;
    end
    st[7] = 1'b1;
    srd(`SMB_OFS_STATUS, d);
    chk(d, st);
    for (int p = 0; p < 4; p++)
    begin
      swr(`SMB_OFS_CONTROL, {6'h00, 2'(p)});
      chk({prio, irq}, {2'(p), p != 0});
    end
    for (int i = 0; i < 3; i++)
    begin
      srd(8'(`SMB_OFS_DATA0 + i), d);
      chk(d, ts[i]);
      st[4 + i] = 1'b0;
    end
    swr(`SMB_OFS_STATUS, rnd());
    st[7] = 1'b0;
    m.mread(`SMB_EXT_STATUS, d, oe);
    chk({d, irq}, {st, 1'b0});
    // Priority is still nonzero here, so a master data 0 write must interrupt
    m.mwrite(2'h0, rnd());
    {st[7], st[4]} = 2'h3;
    srd(`SMB_OFS_STATUS, d);
    chk({d, irq}, {st, 1'b1});
    for (int k = 0; k < 4; k++)
    begin
      e = rnd();
      {pinHi, pinLo} = e[1:0];
      swr(`SMB_OFS_CONTROL, {1'b1, 3'h0, 2'(k), 2'h0});
      chk({spEn, dirOut, aux}, {k == 2, k == 1, k == 3});
      srd(`SMB_OFS_CONTROL, d);
      chk(d, {1'b0, e[1:0], 5'h00});
    end
    srd(8'h25, d);
    chk(d, 8'h00);
    doReset(`SMB_BOOT_COLD);
    chk({halt, spEn}, 2'h3);
    for (int k = 0; k < 24; k++)
      bq[k] = rnd();
    fork
      for (int k = 0; k < 24; k++)
      begin
        m.mpoll(`SMB_ST_IN_FULL0, ok);
        chk(ok, 1'b1);
        m.mwrite(2'h0, bq[k]);
      end
      begin
        // Stores stall long enough that the FIFO must refuse bytes
        repeat (400) @(posedge ref_clk);
        srd(`SMB_OFS_STATUS, d);
        chk(d[`SMB_ST_IN_FULL0], 1'b1);
        for (int k = 0; k < 8; k++)
        begin
          for (int w = 0; w < 2000 && storeValid !== 1'b1; w++)
            @(posedge ref_clk) #1;
          chk(storeValid, 1'b1);
          chk({bootIo, bootAddr}, {bq[3 * k], bq[3 * k + 1]});
          chk(bootData, bq[3 * k + 2]);
          e = rnd();
          repeat (e[1:0]) @(posedge ref_clk);
          #1;
          storeReady = 1'b1;
          @(posedge ref_clk);
          #1;
          storeReady = 1'b0;
        end
      end
    join
    {pinHi, pinLo} = `SMB_BOOT_RUN;
    for (int w = 0; w < 50 && exec !== 1'b1; w++)
      @(posedge ref_clk) #1;
    chk(exec, 1'b1);
    @(posedge ref_clk);
    #1;
    chk({exec, halt}, 2'h0);
    results();
  end

  initial
  begin
    #400000;
    n_mismatch++;
    results();
  end
endmodule
